//--- hw/sci_id_regs.sv
// identification and capability register bank, two read ports
// assumes both access sides present address and strobes synchronous to sys_clk
//
// What this block does
// [R1] software never writes reserved register addresses
// [R2] writers drive reserved bits of implemented registers to zero
// [R3] readers ignore reserved read values; device returns zero there
// [R4] configuration image holds zero in reserved words and loaded bits
// [R5] 8-bit controller type at address 0, read-only from both sides
// [R6] 8-bit read-only revision holding the major version
// [R7] 16-bit read-only build: minor in [7:4], maintenance in [3:0]
// [R8] read-only byte gives count of memory mapping unit channels
// [R9] read-only byte gives count of buffer sync manager channels
// [R10] read-only byte gives process memory size in kilobytes
// [R11] two-bit code per port, port zero lowest, four ports
// [R12] feature bit zero: zero bit-granular, one byte-granular mapping
// [R13] sync-pulse output registers exist only when control bit ten set
// [R14] latch-input registers exist only when control bit eleven set
// [R15] receive time registers exist with timestamps, clock, or 3-4 ports
// [R16] digital output and input words exist only with digital I/O variant
// [R17] unlisted reserved addresses read zero, writes have no effect
// [R18] multi-byte registers place least significant byte at lowest address
// [R19] writes to identification registers are ignored
`timescale 1ns/1ps
module sci_id_regs
   import sci_pkg::*;
#(
   parameter logic [7:0] CTRL_TYPE    = 8'hA5, // arbitrary identity value
   parameter logic [7:0] MAJOR_VER    = 8'h01,
   parameter logic [3:0] MINOR_VER    = 4'h0,
   parameter logic [3:0] MAINT_VER    = 4'h0,
   parameter logic [7:0] BUILD_HI     = 8'h00,
   parameter int         MAP_UNITS    = 8,
   parameter int         SYNC_UNITS   = 8,
   parameter int         RAM_KBYTES   = 8,
   parameter logic [7:0] PORT_CFG     = 8'h0F,
   parameter logic       BYTE_GRAN    = 1'b0,
   parameter logic [6:0] FEAT_LO_REST = 7'h00,
   parameter logic [7:0] FEAT_HI      = 8'h00
)(
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // network side read port
   input  wire logic        net_rd,
   input  wire logic        net_wr,
   input  wire logic [15:0] net_addr,
   input  wire logic [7:0]  net_wdata,
   output logic      [7:0]  net_rdata,
   output logic             net_rvalid,
   // local process interface read port
   input  wire logic        loc_rd,
   input  wire logic        loc_wr,
   input  wire logic [15:0] loc_addr,
   input  wire logic [7:0]  loc_wdata,
   output logic      [7:0]  loc_rdata,
   output logic             loc_rvalid,
   // optional group qualifiers
   input  wire logic        sync_out_en,
   input  wire logic        latch_in_en,
   input  wire logic        rx_time_en,
   input  wire logic        dclock_en,
   input  wire logic        digital_io_sel,
   // presence flags for optional register groups
   output logic             sync_out_present,
   output logic             latch_in_present,
   output logic             rx_time_present,
   output logic             digital_io_present
);
   import sci_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks: every count must fit its one-byte register
   // ------------------------------------------------------------
   if (MAP_UNITS < 0 || MAP_UNITS > 255) begin : g_bad_map
      $error("MAP_UNITS out of range");
   end
   if (SYNC_UNITS < 0 || SYNC_UNITS > 255) begin : g_bad_sync
      $error("SYNC_UNITS out of range");
   end
   if (RAM_KBYTES < 0 || RAM_KBYTES > 255) begin : g_bad_ram
      $error("RAM_KBYTES out of range");
   end

   // ------------------------------------------------------------
   // fixed register image
   // ------------------------------------------------------------
   wire logic [7:0]  map_cnt   = 8'(MAP_UNITS);
   wire logic [7:0]  sync_cnt  = 8'(SYNC_UNITS);
   wire logic [7:0]  ram_size  = 8'(RAM_KBYTES);
   wire logic [15:0] build_val = {BUILD_HI,
                                  MINOR_VER, MAINT_VER}; // [R7]
   wire logic [7:0]  feat_lo   = {FEAT_LO_REST, BYTE_GRAN}; // [R12]
   wire logic [2:0]  port_count;

   // count ports that are present, for the receive time rule
   genvar g;
   wire logic [2:0] port_acc [0:SCI_PORTS];
   assign port_acc[0] = 3'h0;
   generate
      for (g = 0; g < SCI_PORTS; g++) begin : g_port
         // port g occupies bits [2g+1:2g], port zero lowest
         assign port_acc[g+1] = port_acc[g] +
            3'(PORT_CFG[2*g +: 2] != SCI_PORT_ABSENT);
      end
   endgenerate
   assign port_count = port_acc[SCI_PORTS];

   // ------------------------------------------------------------
   // read decode, shared by both access sides
   // ------------------------------------------------------------
   function automatic logic [7:0] id_read(input logic [15:0] a);
      logic [7:0] d;
      d = SCI_RESET_BYTE; // [R17] [R3]
      case (a)
         SCI_ADDR_TYPE:      d = CTRL_TYPE;        // [R5]
         SCI_ADDR_REVISION:  d = MAJOR_VER;        // [R6]
         SCI_ADDR_BUILD_LO:  d = build_val[7:0];   // [R18]
         SCI_ADDR_BUILD_HI:  d = build_val[15:8];  // [R18]
         SCI_ADDR_MAP_CNT:   d = map_cnt;          // [R8]
         SCI_ADDR_SYNC_CNT:  d = sync_cnt;         // [R9]
         SCI_ADDR_RAM_SIZE:  d = ram_size;         // [R10]
         SCI_ADDR_PORT_DESC: d = PORT_CFG;         // [R11]
         SCI_ADDR_FEAT_LO:   d = feat_lo;          // [R12] [R18]
         SCI_ADDR_FEAT_HI:   d = FEAT_HI;
         default:            d = SCI_RESET_BYTE;
      endcase
      return d;
   endfunction

   wire logic [7:0] next_net_rdata = net_rd ? id_read(net_addr) : SCI_RESET_BYTE;
   wire logic [7:0] next_loc_rdata = loc_rd ? id_read(loc_addr) : SCI_RESET_BYTE;

   // presence of optional groups
   wire logic next_rx_time = rx_time_en | dclock_en
                           | (port_count >= 3'h3); // [R15]

   // ------------------------------------------------------------
   // registered outputs; writes never reach the image
   // ------------------------------------------------------------
   // read data falls back to zero between reads, so an idle side
   // never shows a stale byte from an earlier access
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         net_rdata  <= SCI_RESET_BYTE;
         net_rvalid <= SCI_RESET_BIT;
         loc_rdata  <= SCI_RESET_BYTE;
         loc_rvalid <= SCI_RESET_BIT;
      end else begin
         net_rdata  <= next_net_rdata;  // [R19]
         net_rvalid <= net_rd;
         loc_rdata  <= next_loc_rdata;  // [R19]
         loc_rvalid <= loc_rd;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sync_out_present   <= SCI_RESET_BIT;
         latch_in_present   <= SCI_RESET_BIT;
         rx_time_present    <= SCI_RESET_BIT;
         digital_io_present <= SCI_RESET_BIT;
      end else begin
         sync_out_present   <= sync_out_en;     // [R13]
         latch_in_present   <= latch_in_en;     // [R14]
         rx_time_present    <= next_rx_time;    // [R15]
         digital_io_present <= digital_io_sel;  // [R16]
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   type_read_a: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
      net_rd && net_addr == SCI_ADDR_TYPE |=> net_rvalid && net_rdata == CTRL_TYPE)
      else $error("type read wrong");
   rev_read_a: assert property (@(posedge sys_clk) disable iff (reset) // [R6]
      loc_rd && loc_addr == SCI_ADDR_REVISION |=> loc_rdata == MAJOR_VER)
      else $error("revision read wrong");
   build_lsb_a: assert property (@(posedge sys_clk) disable iff (reset) // [R7]
      net_rd && net_addr == SCI_ADDR_BUILD_LO |=> net_rdata == {MINOR_VER, MAINT_VER})
      else $error("build low byte wrong");
   map_count_a: assert property (@(posedge sys_clk) disable iff (reset) // [R8]
      loc_rd && loc_addr == SCI_ADDR_MAP_CNT |=> loc_rdata == 8'(MAP_UNITS))
      else $error("map unit count wrong");
   sync_count_a: assert property (@(posedge sys_clk) disable iff (reset) // [R9]
      net_rd && net_addr == SCI_ADDR_SYNC_CNT |=> net_rdata == 8'(SYNC_UNITS))
      else $error("sync unit count wrong");
   ram_size_a: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
      loc_rd && loc_addr == SCI_ADDR_RAM_SIZE |=> loc_rdata == 8'(RAM_KBYTES))
      else $error("ram size wrong");
   port_desc_a: assert property (@(posedge sys_clk) disable iff (reset) // [R11]
      net_rd && net_addr == SCI_ADDR_PORT_DESC |=> net_rdata == PORT_CFG)
      else $error("port descriptor wrong");
   gran_bit_a: assert property (@(posedge sys_clk) disable iff (reset) // [R12]
      loc_rd && loc_addr == SCI_ADDR_FEAT_LO |=> loc_rdata[SCI_FEAT_GRAN_POS] == BYTE_GRAN)
      else $error("granularity bit wrong");
   sync_group_a: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
      sync_out_en ##1 sync_out_en |-> sync_out_present)
      else $error("sync group presence wrong");
   latch_group_a: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
      !latch_in_en |=> !latch_in_present)
      else $error("latch group presence wrong");
   rx_time_a: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
      (rx_time_en || dclock_en || port_count >= 3'h3) |=> rx_time_present)
      else $error("receive time presence wrong");
   dio_group_a: assert property (@(posedge sys_clk) disable iff (reset) // [R16]
      digital_io_sel != $past(digital_io_sel) |=> digital_io_present == $past(digital_io_sel))
      else $error("digital io presence wrong");
   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
      net_rd && net_addr > SCI_ADDR_FEAT_HI |=> net_rdata == 8'h00)
      else $error("reserved read not zero");
   build_msb_a: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
      loc_rd && loc_addr == SCI_ADDR_BUILD_HI |=> loc_rdata == BUILD_HI)
      else $error("build high byte wrong");
   write_ignored_a: assert property (@(posedge sys_clk) disable iff (reset) // [R19]
      net_wr ##[1:4] (net_rd && net_addr == SCI_ADDR_TYPE) |=> net_rdata == CTRL_TYPE)
      else $error("write altered image");

   // ------------------------------------------------------------
   // assertions: the same image seen from the other side
   // ------------------------------------------------------------
   loc_type_a: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
      loc_rd && loc_addr == SCI_ADDR_TYPE |=> loc_rvalid && loc_rdata == CTRL_TYPE)
      else $error("local type read wrong");
   net_rev_a: assert property (@(posedge sys_clk) disable iff (reset) // [R6]
      net_rd && net_addr == SCI_ADDR_REVISION |=> net_rdata == MAJOR_VER)
      else $error("network revision read wrong");
   loc_build_lsb_a: assert property (@(posedge sys_clk) disable iff (reset) // [R7]
      loc_rd && loc_addr == SCI_ADDR_BUILD_LO |=> loc_rdata == {MINOR_VER, MAINT_VER})
      else $error("local build low byte wrong");
   net_map_count_a: assert property (@(posedge sys_clk) disable iff (reset) // [R8]
      net_rd && net_addr == SCI_ADDR_MAP_CNT |=> net_rdata == 8'(MAP_UNITS))
      else $error("network map unit count wrong");
   loc_sync_count_a: assert property (@(posedge sys_clk) disable iff (reset) // [R9]
      loc_rd && loc_addr == SCI_ADDR_SYNC_CNT |=> loc_rdata == 8'(SYNC_UNITS))
      else $error("local sync unit count wrong");
   net_ram_size_a: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
      net_rd && net_addr == SCI_ADDR_RAM_SIZE |=> net_rdata == 8'(RAM_KBYTES))
      else $error("network ram size wrong");
   loc_port_desc_a: assert property (@(posedge sys_clk) disable iff (reset) // [R11]
      loc_rd && loc_addr == SCI_ADDR_PORT_DESC |=> loc_rdata == PORT_CFG)
      else $error("local port descriptor wrong");
   net_gran_bit_a: assert property (@(posedge sys_clk) disable iff (reset) // [R12]
      net_rd && net_addr == SCI_ADDR_FEAT_LO |=> net_rdata[SCI_FEAT_GRAN_POS] == BYTE_GRAN)
      else $error("network granularity bit wrong");
   net_build_msb_a: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
      net_rd && net_addr == SCI_ADDR_BUILD_HI |=> net_rdata == BUILD_HI)
      else $error("network build high byte wrong");
   net_feat_msb_a: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
      net_rd && net_addr == SCI_ADDR_FEAT_HI |=> net_rdata == FEAT_HI)
      else $error("network feature high byte wrong");
   loc_feat_msb_a: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
      loc_rd && loc_addr == SCI_ADDR_FEAT_HI |=> loc_rdata == FEAT_HI)
      else $error("local feature high byte wrong");
   loc_reserved_a: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
      loc_rd && loc_addr > SCI_ADDR_FEAT_HI |=> loc_rdata == 8'h00)
      else $error("local reserved read not zero");
   loc_write_a: assert property (@(posedge sys_clk) disable iff (reset) // [R19]
      loc_wr ##[1:4] (loc_rd && loc_addr == SCI_ADDR_TYPE) |=> loc_rdata == CTRL_TYPE)
      else $error("local write altered image");
   both_sides_a: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
      net_rd && loc_rd && net_addr == loc_addr |=> net_rdata == loc_rdata)
      else $error("sides disagree on one address");

   // ------------------------------------------------------------
   // assertions: answer timing and idle level
   // ------------------------------------------------------------
   net_answer_a: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
      net_rd |=> net_rvalid)
      else $error("network read not answered");
   loc_answer_a: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
      loc_rd |=> loc_rvalid)
      else $error("local read not answered");
   net_idle_zero_a: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
      !net_rd |=> !net_rvalid && net_rdata == 8'h00)
      else $error("network idle answer not zero");
   loc_idle_zero_a: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
      !loc_rd |=> !loc_rvalid && loc_rdata == 8'h00)
      else $error("local idle answer not zero");

   // ------------------------------------------------------------
   // assertions: optional groups switched off and on
   // ------------------------------------------------------------
   sync_group_off_a: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
      !sync_out_en |=> !sync_out_present)
      else $error("sync group present while disabled");
   latch_group_on_a: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
      latch_in_en |=> latch_in_present)
      else $error("latch group missing while enabled");
   rx_time_off_a: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
      !rx_time_en && !dclock_en && port_count < 3'h3 |=> !rx_time_present)
      else $error("receive time present without cause");
   dio_group_on_a: assert property (@(posedge sys_clk) disable iff (reset) // [R16]
      digital_io_sel |=> digital_io_present)
      else $error("digital io group missing while selected");
   dio_group_off_a: assert property (@(posedge sys_clk) disable iff (reset) // [R16]
      !digital_io_sel |=> !digital_io_present)
      else $error("digital io group present while not selected");

   // ------------------------------------------------------------
   // covers for the main scenarios
   // ------------------------------------------------------------
   net_read_c:   cover property (@(posedge sys_clk) net_rd && net_addr == SCI_ADDR_TYPE);
   loc_read_c:   cover property (@(posedge sys_clk) loc_rd && loc_addr == SCI_ADDR_FEAT_HI);
   both_read_c:  cover property (@(posedge sys_clk) net_rd && loc_rd);
   write_try_c:  cover property (@(posedge sys_clk) net_wr || loc_wr);
   presence_c:   cover property (@(posedge sys_clk) sync_out_present && latch_in_present
                                 && rx_time_present && digital_io_present);
endmodule

//--- shared/sci_pkg.sv
// identification register bank constants
// assumes byte-addressed register space with 16-bit local addresses
package sci_pkg;
   // ------------------------------------------------------------
   // address map
   // ------------------------------------------------------------
   localparam logic [15:0] SCI_ADDR_TYPE      = 16'h0000;
   localparam logic [15:0] SCI_ADDR_REVISION  = 16'h0001;
   localparam logic [15:0] SCI_ADDR_BUILD_LO  = 16'h0002;
   localparam logic [15:0] SCI_ADDR_BUILD_HI  = 16'h0003;
   localparam logic [15:0] SCI_ADDR_MAP_CNT   = 16'h0004;
   localparam logic [15:0] SCI_ADDR_SYNC_CNT  = 16'h0005;
   localparam logic [15:0] SCI_ADDR_RAM_SIZE  = 16'h0006;
   localparam logic [15:0] SCI_ADDR_PORT_DESC = 16'h0007;
   localparam logic [15:0] SCI_ADDR_FEAT_LO   = 16'h0008;
   localparam logic [15:0] SCI_ADDR_FEAT_HI   = 16'h0009;
   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int SCI_BUILD_MINOR_POS = 4;
   localparam int SCI_BUILD_MAINT_POS = 0;
   localparam int SCI_FEAT_GRAN_POS   = 0;
   localparam int SCI_PORTS           = 4;
   localparam logic [1:0] SCI_PORT_ABSENT = 2'h0;
   localparam logic [1:0] SCI_PORT_UNCONF = 2'h1;
   localparam logic [1:0] SCI_PORT_BACKPL = 2'h2;
   localparam logic [1:0] SCI_PORT_MII    = 2'h3;
   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic [7:0] SCI_RESET_BYTE = 8'h00;
   localparam logic       SCI_RESET_BIT  = 1'b0;
   typedef enum logic [1:0] {
      SCI_IDLE  = 2'b00,
      SCI_READY = 2'b01
   } sci_state_e;
endpackage

//--- verif/sci_host_model.sv
// byte-wide register master for one access side of the id bank
// assumes the bank answers at the taking edge, one cycle after the strobe is raised
`timescale 1ns/1ps
module sci_host_model (
   input  wire logic        sys_clk,
   output logic             rd,
   output logic             wr,
   output logic      [15:0] addr,
   output logic      [7:0]  wdata,
   input  wire logic [7:0]  rdata,
   input  wire logic        rvalid
);
   initial begin
      rd = 1'b0;
      wr = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
   end
   // the byte is handed back as seen; callers decide whether it matters
   task automatic rd_byte(input logic [15:0] a, output logic [7:0] d, output logic v);
      @(posedge sys_clk);
      #2;
      rd = 1'b1;
      addr = a;
      @(posedge sys_clk);
      #2;
      rd = 1'b0;
      addr = ~a;
      v = rvalid;
      d = rdata;
   endtask
   // callers only write implemented places, reserved bits zero
   task automatic wr_byte(input logic [15:0] a, input logic [7:0] b);
      @(posedge sys_clk);
      #2;
      wr = 1'b1;
      addr = a;
      wdata = b;
      @(posedge sys_clk);
      #2;
      wr = 1'b0;
      addr = ~a;
      wdata = ~b;
   endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the identification register bank
// assumes both access sides are driven by partner models
`timescale 1ns/1ps
module tb;
   import sci_pkg::*;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic [4:0]  en = 5'h00;
   logic [15:0] net_addr, loc_addr;
   logic [7:0]  net_wdata, loc_wdata, net_rdata, loc_rdata;
   logic        net_rd, net_wr, net_rvalid, loc_rd, loc_wr, loc_rvalid;
   wire logic [3:0] pres;
   int          errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   // the configured image keeps every reserved feature bit at its zero default
   sci_id_regs #(.CTRL_TYPE(8'h5A), .MINOR_VER(4'h3), .MAINT_VER(4'h4), .MAP_UNITS(3),
      .BYTE_GRAN(1'b1)) uut (
      .sys_clk(sys_clk), .reset(reset), .net_rd(net_rd), .net_wr(net_wr),
      .net_addr(net_addr), .net_wdata(net_wdata), .net_rdata(net_rdata),
      .net_rvalid(net_rvalid), .loc_rd(loc_rd), .loc_wr(loc_wr), .loc_addr(loc_addr),
      .loc_wdata(loc_wdata), .loc_rdata(loc_rdata), .loc_rvalid(loc_rvalid),
      .sync_out_en(en[4]), .latch_in_en(en[3]), .rx_time_en(en[2]), .dclock_en(en[1]),
      .digital_io_sel(en[0]), .sync_out_present(pres[3]), .latch_in_present(pres[2]),
      .rx_time_present(pres[1]), .digital_io_present(pres[0]));
   sci_host_model net_host (.sys_clk(sys_clk), .rd(net_rd), .wr(net_wr), .addr(net_addr),
      .wdata(net_wdata), .rdata(net_rdata), .rvalid(net_rvalid));
   sci_host_model loc_host (.sys_clk(sys_clk), .rd(loc_rd), .wr(loc_wr), .addr(loc_addr),
      .wdata(loc_wdata), .rdata(loc_rdata), .rvalid(loc_rvalid));
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         tally_and_finish();
      end
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] exp_byte(input logic [15:0] a);
      case (a)
         SCI_ADDR_TYPE:      return 8'h5A;
         SCI_ADDR_REVISION:  return 8'h01;
         SCI_ADDR_BUILD_LO:  return 8'h34;
         SCI_ADDR_BUILD_HI:  return 8'h00;
         SCI_ADDR_MAP_CNT:   return 8'h03;
         SCI_ADDR_SYNC_CNT:  return 8'h08;
         SCI_ADDR_RAM_SIZE:  return 8'h08;
         SCI_ADDR_PORT_DESC: return 8'h0F;
         SCI_ADDR_FEAT_LO:   return 8'h01;
         default:            return 8'h00;
      endcase
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic read_both(input logic [15:0] a);
      logic [7:0] dn, dl;
      logic       vn, vl;
      fork
         net_host.rd_byte(a, dn, vn);
         loc_host.rd_byte(a, dl, vl);
      join
      check({7'h00, vn & vl}, 8'h01, "read answered");
      check(dn, exp_byte(a), "network side byte");
      check(dl, exp_byte(a), "local side byte");
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_read_all();
      for (int a = 0; a < 10; a++) read_both(16'(a));
      $display("test_read_all done");
   endtask
   task automatic test_writes_ignored();
      for (int a = 0; a < 10; a++) begin
         net_host.wr_byte(16'(a), (a < 8) ? 8'hFF : 8'h00);
         loc_host.wr_byte(16'(a), (a < 8) ? 8'hC3 : 8'h00);
         read_both(16'(a));
      end
      $display("test_writes_ignored done");
   endtask
   task automatic test_unmapped();
      logic [15:0] adr [5] = '{16'h000A, 16'h000F, 16'h0100, 16'h0F00, 16'h1000};
      foreach (adr[i]) read_both(adr[i]);
      @(posedge sys_clk);
      #2;
      check({7'h00, net_rvalid}, 8'h00, "idle network valid");
      check(net_rdata, 8'h00, "idle network answer");
      $display("test_unmapped done");
   endtask
   task automatic test_presence();
      logic [4:0] pat [7] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h1F};
      foreach (pat[i]) begin
         @(posedge sys_clk);
         #2;
         en = pat[i];
         repeat (2) @(posedge sys_clk);
         #2;
         check({7'h00, pres[3]}, {7'h00, en[4]}, "sync out group");
         check({7'h00, pres[2]}, {7'h00, en[3]}, "latch in group");
         check({7'h00, pres[1]}, {7'h00, en[2] | en[1]}, "receive time group");
         check({7'h00, pres[0]}, {7'h00, en[0]}, "digital io group");
      end
      $display("test_presence done");
   endtask
   task automatic test_reset();
      logic [7:0] d;
      logic       v;
      fork
         net_host.rd_byte(SCI_ADDR_TYPE, d, v);
         begin
            @(posedge sys_clk);
            #2;
            reset = 1'b1;
         end
      join
      check({7'h00, v}, 8'h00, "valid under reset");
      check(d, 8'h00, "data under reset");
      check({4'h0, pres}, 8'h00, "groups under reset");
      @(posedge sys_clk);
      #2;
      reset = 1'b0;
      read_both(SCI_ADDR_TYPE);
      $display("test_reset done");
   endtask
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      #2;
      reset = 1'b0;
      test_read_all();
      test_writes_ignored();
      test_unmapped();
      test_presence();
      test_reset();
      tally_and_finish();
   end
endmodule
